/* src/rsc_pkg.sv */
// Package for the reset strap capture block: field layout, reset values, APB map
package rsc_pkg;

  localparam int RSC_RATIO_W = 3;

  // Ratio codes; core clock multiplier in half steps (n*2)
  localparam logic [2:0] RSC_RATIO_2P0 = 3'h0;
  localparam logic [2:0] RSC_RATIO_2P5 = 3'h1;
  localparam logic [2:0] RSC_RATIO_3P0 = 3'h2;
  localparam logic [2:0] RSC_RATIO_3P5 = 3'h3;
  localparam logic [2:0] RSC_RATIO_4P0 = 3'h4;
  localparam logic [2:0] RSC_RATIO_5P0 = 3'h5;
  localparam logic [3:0] RSC_HALF_2P0 = 4'h4;
  localparam logic [3:0] RSC_HALF_2P5 = 4'h5;
  localparam logic [3:0] RSC_HALF_3P0 = 4'h6;
  localparam logic [3:0] RSC_HALF_3P5 = 4'h7;
  localparam logic [3:0] RSC_HALF_4P0 = 4'h8;
  localparam logic [3:0] RSC_HALF_5P0 = 4'ha;

  // Sysclk band limits in MHz
  localparam int RSC_BAND_LO_MHZ = 50;
  localparam int RSC_BAND_HI_MHZ = 100;

  // Register byte offsets
  localparam logic [11:0] RSC_OFF_STRAP = 12'h000;
  localparam logic [11:0] RSC_OFF_CFG = 12'h004;
  localparam logic [11:0] RSC_OFF_ID = 12'h008;

  // Field positions in the strap register
  localparam int RSC_BIT_DLL_SKIP = 0;
  localparam int RSC_BIT_PROM_BOOT = 1;
  localparam int RSC_BIT_IRQ_ARM = 2;
  localparam int RSC_BIT_RATIO = 4;
  localparam int RSC_BIT_PLL_SKIP = 8;
  localparam int RSC_BIT_SYSCLK = 9;
  localparam int RSC_BIT_RATIO_BAD = 12;
  // Field positions in the config register
  localparam int RSC_BIT_OVR_EN = 0;

  // Every default strap reads as zero (internal pulldown)
  localparam logic [9:0] RSC_STRAP_RST = 10'h000;
  localparam logic RSC_OVR_RST = 1'b0;
  // Arbitrary block identity value
  localparam logic [31:0] RSC_ID_VALUE = 32'h5a5a0001;

  typedef struct packed {
    logic dll_skip;
    logic prom_boot_strap;
    logic interrupt_arm_strap;
    logic [2:0] core_ratio_strap;
    logic pll_skip;
    logic sysclk_range_strap;
  } rsc_straps_s;

  typedef struct packed {
    logic io_clk_bypass_dll;
    logic boot_from_prom;
    logic boot_wait_external;
    logic irq_enabled;
    logic irq_edge_mode;
    logic [3:0] core_ratio_half;
    logic ratio_code_bad;
    logic core_clk_bypass_pll;
    logic sysclk_below_band;
  } rsc_config_s;

endpackage

/* src/rsc_capture.sv */
// Strap capture during reset, decoded configuration and APB status port
//
// Behaviour
// (R1) Sample strap pins only while reset held
// (R2) Unconnected strap reads as default low
// (R3) Board holds pin high for non-default mode
// (R4) DLL skip strap bypasses I/O clock DLL
// (R5) Boot strap: prom boot or wait
// (R6) Interrupt strap: disabled-level or enabled-edge
// (R7) Three-bit ratio code selects core multiplier
// (R8) PLL skip strap bypasses core clock PLL
// (R9) Sysclk range strap flags below-band input
// (R10) Latched values hold until next reset
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module rsc_capture
  import rsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  // Strap pins, sampled as the shared pins read during reset
  input wire logic timer0_expire_out,
  input wire logic boot_memory_select,
  input wire logic bus_owner_out,
  input wire logic link0_direction,
  input wire logic link1_direction,
  input wire logic link2_direction,
  input wire logic link3_direction,
  input wire logic bus_hold_out,
  // High while the shared pins carry their ordinary function
  output logic pins_normal,
  output rsc_config_s cfg,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Reset is asynchronous, so the pins cannot be caught by the reset branch.
  // A separate process with no reset samples them on every edge while held.
  logic run;
  logic [9:0] sample;
  logic [9:0] held;
  logic ovr_en;
  rsc_straps_s st;

  wire [9:0] pins_now = {bus_hold_out, link3_direction, link2_direction, link1_direction,
                         link0_direction, bus_owner_out, boot_memory_select,
                         timer0_expire_out, 2'b00};

  always_ff @(posedge pclk) begin
    if (!presetn) begin
      sample <= pins_now; // [R1] [R2]
    end
  end

  // First edge after release latches the sample and freezes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      held <= RSC_STRAP_RST;
    end else if (!run) begin
      run <= 1'b1;
      held <= sample; // [R10]
    end
  end

  assign pins_normal = run; // [R1]

  assign st.dll_skip = held[2];
  assign st.prom_boot_strap = held[3];
  assign st.interrupt_arm_strap = held[4];
  assign st.core_ratio_strap = held[7:5];
  assign st.pll_skip = held[9];
  assign st.sysclk_range_strap = held[8];

  logic [3:0] ratio_half;
  always_comb begin
    case (st.core_ratio_strap) // [R7]
      RSC_RATIO_2P0: ratio_half = RSC_HALF_2P0;
      RSC_RATIO_2P5: ratio_half = RSC_HALF_2P5;
      RSC_RATIO_3P0: ratio_half = RSC_HALF_3P0;
      RSC_RATIO_3P5: ratio_half = RSC_HALF_3P5;
      RSC_RATIO_4P0: ratio_half = RSC_HALF_4P0;
      RSC_RATIO_5P0: ratio_half = RSC_HALF_5P0;
      default: ratio_half = RSC_HALF_2P0;
    endcase
  end

  wire ratio_bad = st.core_ratio_strap > RSC_RATIO_5P0;
  // Override lets software force every bypass off for bring-up
  wire allow = run && !ovr_en;

  assign cfg.io_clk_bypass_dll = allow && st.dll_skip; // [R4]
  assign cfg.boot_from_prom = run && !st.prom_boot_strap; // [R5]
  assign cfg.boot_wait_external = run && st.prom_boot_strap; // [R5]
  assign cfg.irq_enabled = run && st.interrupt_arm_strap; // [R6]
  assign cfg.irq_edge_mode = run && st.interrupt_arm_strap; // [R6]
  assign cfg.core_ratio_half = ratio_half; // [R7]
  assign cfg.ratio_code_bad = ratio_bad;
  assign cfg.core_clk_bypass_pll = allow && st.pll_skip; // [R8]
  assign cfg.sysclk_below_band = st.sysclk_range_strap; // [R9]

  // APB: zero wait states, unmapped address answers with pslverr
  wire acc = psel && penable;
  wire hit_strap = paddr == RSC_OFF_STRAP;
  wire hit_cfg = paddr == RSC_OFF_CFG;
  wire hit_id = paddr == RSC_OFF_ID;
  wire mapped = hit_strap || hit_cfg || hit_id;
  wire wr_cfg = acc && pwrite && hit_cfg;

  logic [31:0] strap_word;
  always_comb begin
    strap_word = 32'h0;
    strap_word[RSC_BIT_DLL_SKIP] = st.dll_skip;
    strap_word[RSC_BIT_PROM_BOOT] = st.prom_boot_strap;
    strap_word[RSC_BIT_IRQ_ARM] = st.interrupt_arm_strap;
    strap_word[RSC_BIT_RATIO +: RSC_RATIO_W] = st.core_ratio_strap;
    strap_word[RSC_BIT_PLL_SKIP] = st.pll_skip;
    strap_word[RSC_BIT_SYSCLK] = st.sysclk_range_strap;
    strap_word[RSC_BIT_RATIO_BAD] = ratio_bad;
  end

  wire [31:0] rd_mux = hit_strap ? strap_word :
                       hit_cfg ? {31'h0, ovr_en} :
                       hit_id ? RSC_ID_VALUE : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_en <= RSC_OVR_RST;
      prdata <= 32'h0;
    end else begin
      if (wr_cfg) begin
        ovr_en <= pwdata[RSC_BIT_OVR_EN];
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Checks
  sequence s_first;
    !run ##1 run;
  endsequence
  // Latch holds even while the shared pins carry traffic
  property p_hold;
    @(posedge pclk) disable iff (!presetn) run |=> $stable(held);
  endproperty
  a_hold: assert property (p_hold) else $error("strap latch changed after release"); // [R10]
  // Pins seen at the last edge in reset reach the latch one edge on and are checked the edge after
  property p_latch_seq;
    @(posedge pclk) disable iff (!presetn) s_first |-> held == $past(pins_now, 2);
  endproperty
  a_latch_seq: assert property (p_latch_seq) else $error("strap latch missed sample"); // [R10]
  property p_pins;
    @(posedge pclk) disable iff (!presetn) !pins_normal |=> pins_normal;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not returned after reset"); // [R1]
  // No disable here: the reset state itself is what is checked
  property p_reset_idle;
    @(posedge pclk) !presetn |->
      !pins_normal && !cfg.io_clk_bypass_dll && !cfg.core_clk_bypass_pll;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset"); // [R1]
  property p_dll;
    @(posedge pclk) disable iff (!presetn)
      cfg.io_clk_bypass_dll |-> st.dll_skip && !ovr_en;
  endproperty
  a_dll: assert property (p_dll) else $error("dll bypass without strap"); // [R4]
  property p_boot;
    @(posedge pclk) disable iff (!presetn)
      run |-> cfg.boot_from_prom != cfg.boot_wait_external;
  endproperty
  a_boot: assert property (p_boot) else $error("boot choice not exclusive"); // [R5]
  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      run |-> cfg.irq_edge_mode == st.interrupt_arm_strap && cfg.irq_enabled == cfg.irq_edge_mode;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt default mismatch"); // [R6]
  property p_ratio;
    @(posedge pclk) disable iff (!presetn)
      st.core_ratio_strap == RSC_RATIO_2P5 |-> cfg.core_ratio_half == RSC_HALF_2P5;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio decode wrong"); // [R7]
  property p_pll;
    @(posedge pclk) disable iff (!presetn)
      (run && st.pll_skip && !ovr_en) |-> cfg.core_clk_bypass_pll;
  endproperty
  a_pll: assert property (p_pll) else $error("pll bypass missing"); // [R8]
  property p_band;
    @(posedge pclk) disable iff (!presetn)
      cfg.sysclk_below_band == held[8];
  endproperty
  a_band: assert property (p_band) else $error("sysclk band wrong"); // [R9]
  property p_ratio5;
    @(posedge pclk) disable iff (!presetn)
      st.core_ratio_strap == RSC_RATIO_5P0 |-> cfg.core_ratio_half == RSC_HALF_5P0;
  endproperty
  a_ratio5: assert property (p_ratio5) else $error("top ratio decode wrong"); // [R7]
  property p_ratio_bad;
    @(posedge pclk) disable iff (!presetn)
      cfg.ratio_code_bad |-> cfg.core_ratio_half == RSC_HALF_2P0;
  endproperty
  a_ratio_bad: assert property (p_ratio_bad) else $error("reserved ratio not safe"); // [R7]
  // Only a software override may move the decoded outputs after release
  property p_cfg_hold;
    @(posedge pclk) disable iff (!presetn)
      (run && !wr_cfg) |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("decoded config moved"); // [R10]
  // Read data is loaded at setup and must stand through the access phase
  property p_rd;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite) |-> prdata == $past(rd_mux);
  endproperty
  a_rd: assert property (p_rd) else $error("read data not from setup cycle");

endmodule

/* testbench/rsc_board_model.sv */
// Board pulls on the strap pins; ordinary pin traffic once reset ends
`timescale 1ns/10ps
module rsc_board_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pull_up,
  output logic [7:0] pins
);
  logic flip;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
    end
  end
  // Pulldown gives 0 unless pulled up; after reset the pins carry other traffic
  assign pins = !presetn ? pull_up : (flip ? ~pull_up : pull_up ^ 8'h5a);
endmodule

/* testbench/reset_strap_capture_test.sv */
// Bench for strap capture: decode of every strap, hold after reset, APB map
`timescale 1ns/10ps
module reset_strap_capture_test;
  import rsc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, pins_normal, er;
  logic [7:0] pull = 0, pins;
  rsc_config_s cfg, ec;
  int failures = 0, samples_checked = 0;
  logic [7:0] vec[14] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
    8'h30, 8'h38, 8'h40, 8'h80, 8'hff};
  logic [3:0] half[8] = '{RSC_HALF_2P0, RSC_HALF_2P5, RSC_HALF_3P0, RSC_HALF_3P5,
    RSC_HALF_4P0, RSC_HALF_5P0, RSC_HALF_2P0, RSC_HALF_2P0};
  initial forever #20 pclk = ~pclk;
  rsc_board_model u_board (.pclk(pclk), .presetn(presetn), .pull_up(pull), .pins(pins));
  rsc_capture u_dut (.pclk(pclk), .presetn(presetn), .timer0_expire_out(pins[0]),
    .boot_memory_select(pins[1]), .bus_owner_out(pins[2]), .link0_direction(pins[3]),
    .link1_direction(pins[4]), .link2_direction(pins[5]), .link3_direction(pins[7]),
    .bus_hold_out(pins[6]), .pins_normal(pins_normal), .cfg(cfg), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Idle edge so a following call never drives psel twice in one step
    @(posedge pclk);
  endtask
  task automatic cap(logic [7:0] p);
    pull <= p;
    presetn <= 0;
    repeat (3) @(posedge pclk);
    chk("pins_normal_in_reset", 0, pins_normal);
    presetn <= 1;
    @(posedge pclk);
    @(posedge pclk);
    ec = {p[0], !p[1], p[1], p[2], p[2], half[p[5:3]], p[5:3] > 3'h5, p[6], p[7]};
    chk("cfg", 32'(ec), 32'(cfg));
    chk("pins_normal", 1, pins_normal);
  endtask
  task automatic t_decode;
    foreach (vec[i]) begin
      cap(vec[i]);
      apb(0, RSC_OFF_STRAP, 0);
      chk("strap_reg", {19'h0, vec[i][5:3] > 3'h5, 2'h0, vec[i][7:6], 1'b0, vec[i][5:3], 1'b0,
        vec[i][2:0]}, rd);
    end
  endtask
  task automatic t_hold;
    cap(8'hc5);
    repeat (12) @(posedge pclk);
    chk("cfg_held", 32'(ec), 32'(cfg));
    apb(1, RSC_OFF_STRAP, 32'hffffffff);
    apb(0, RSC_OFF_STRAP, 0);
    chk("strap_held", 32'h0000_0305, rd);
  endtask
  task automatic t_regs;
    cap(8'h41);
    @(posedge pclk);
    apb(0, RSC_OFF_ID, 0);
    chk("id", RSC_ID_VALUE, rd);
    apb(0, 12'h00c, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_data", 0, rd);
    apb(1, RSC_OFF_CFG, 1);
    apb(0, RSC_OFF_CFG, 0);
    chk("cfg_reg", 1, rd);
    chk("bypass_off", 0, {cfg.io_clk_bypass_dll, cfg.core_clk_bypass_pll});
    apb(1, RSC_OFF_CFG, 0);
    @(posedge pclk);
    chk("bypass_on", 3, {cfg.io_clk_bypass_dll, cfg.core_clk_bypass_pll});
  endtask
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_decode();
    t_hold();
    t_regs();
    end_sim();
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    end_sim();
  end
endmodule
